// ==== logic/gwc_top.sv ====
/*
 * gwc_top: general-purpose pin configuration, wake pin handling, power
 * mode sequencing and bootstrap hold, with an AHB-Lite register slave.
 * Assumes a single 40 MHz clock, synchronous active-high reset and pad
 * cells outside that resolve output, enable and pull controls.
 */
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
// Behaviour
// R1: host sets each pin direction and mode
// R2: pin state is high, low or float
// R3: output direction drives high, low or releases
// R4: input direction pulls up, down or none
// R5: wake pin rising edge wakes from low power
// R6: after sleep wake, idle only when pin low
// R7: stay in loader while wake pin high at start
// R8: internal pull-down kept on wake pin
// R9: host leaves unused wake pin low or open
// R10: reset pin open-drain, device may pull low
// R11: exactly four independent general-purpose pins
// R12: standby wakes on pin activity, sleep not
// R13: command ready 50 ms / 60 ms after wake
// R14: inputs synchronised before edge detection
`timescale 1ns/1ps
module gwc_top
    import gwc_pkg::*;
#(
    parameter int NGPIO = gwc_pkg::NUM_GPIO,
    parameter int WAKE_STBY_CYC = gwc_pkg::WAKE_STANDBY_CYC,
    parameter int WAKE_SLP_CYC = gwc_pkg::WAKE_SLEEP_CYC,
    parameter int CNT_W = 22
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [3:0] general_io_pin_i,
    output logic [3:0] general_io_pin_o,
    output logic [3:0] general_io_pin_oe,
    output logic [3:0] general_io_pin_pu,
    output logic [3:0] general_io_pin_pd,
    input wire logic wake_request_pin_i,
    output logic wake_request_pin_pd,
    output logic reset_n_pin_o,
    output logic reset_n_pin_oe,
    output logic [1:0] power_mode,
    output logic cmd_ready,
    output logic bootstrap_hold,
    output logic irq
);
    import gwc_pkg::*;

    // ==========================================================
    // elaboration checks
    if (NGPIO != 4) begin : g_bad_ngpio
        $error("gwc_top serves exactly four pins");  // [R11]
    end
    if (WAKE_STBY_CYC < 1 || WAKE_SLP_CYC < 1 || WAKE_SLP_CYC >= (1 << CNT_W)
        || WAKE_STBY_CYC >= (1 << CNT_W)) begin : g_bad_cnt
        $error("gwc_top wake counts do not fit the counter");
    end

    typedef struct packed {
        gwc_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [1:0] settle;
        logic from_sleep;
        logic [3:0] dir;
        logic [7:0] pstate;
        logic [STS_W-1:0] sts;
        logic [STS_W-1:0] ien;
        logic self_rst;
        logic pend;
        logic pend_wr;
        logic [7:0] pend_addr;
        logic hready_o;
        logic [31:0] rdata;
        logic [3:0] pin_o;
        logic [3:0] pin_oe;
        logic [3:0] pin_pu;
        logic [3:0] pin_pd;
        logic wake_pd;
        logic rst_oe;
        logic [1:0] pwr;
        logic ready;
        logic boot;
        logic irq;
    } gwc_top_st_t;

    gwc_top_st_t st_ff;
    gwc_top_st_t nxt_st;

    gwc_edge_if #(.W(5)) edge_bus ();

    assign edge_bus.raw = {wake_request_pin_i, general_io_pin_i};

    gwc_sync_edge #(.W(5)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pins(edge_bus.det)
    );

    // ==========================================================
    // helpers
    // returns {oe, o, pu, pd} for one pin
    function automatic logic [3:0] pad_ctl(input logic is_out, input logic [1:0] ps);
        logic [3:0] r;
        r = 4'h0;
        if (is_out) begin
            if (ps == PS_HIGH) begin
                r = 4'hC;  // [R3]
            end else if (ps == PS_LOW) begin
                r = 4'h8;  // [R3]
            end
        end else begin
            if (ps == PS_HIGH) begin
                r = 4'h2;  // [R4]
            end else if (ps == PS_LOW) begin
                r = 4'h1;  // [R4]
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] pwr_code(input gwc_state_t s);
        logic [1:0] r;
        r = PWR_BUSY;
        if (s == ST_IDLE) begin
            r = PWR_IDLE;
        end else if (s == ST_STANDBY) begin
            r = PWR_STANDBY;
        end else if (s == ST_SLEEP) begin
            r = PWR_SLEEP;
        end
        return r;
    endfunction

    logic wake_rise;
    logic wake_lvl;
    logic gpio_act;
    assign wake_rise = edge_bus.rise[4];
    assign wake_lvl = edge_bus.lvl[4];
    assign gpio_act = |(edge_bus.chg[3:0] & ~st_ff.dir);

    // ==========================================================
    // next state
    always_comb begin
        logic [STS_W-1:0] set_ev;
        logic [STS_W-1:0] clr_ev;
        logic [3:0] pc;
        logic wr_pwr;
        set_ev = '0;
        clr_ev = '0;
        pc = 4'h0;
        wr_pwr = 1'b0;
        nxt_st = st_ff;

        // bus: one wait cycle, then the answer
        nxt_st.hready_o = 1'b1;
        if (st_ff.pend) begin
            nxt_st.pend = 1'b0;
            nxt_st.rdata = 32'h0;
            if (st_ff.pend_wr) begin
                if (st_ff.pend_addr == OFS_DIR) begin
                    nxt_st.dir = hwdata[3:0];  // [R1]
                end else if (st_ff.pend_addr == OFS_PSTATE) begin
                    for (int i = 0; i < 4; i++) begin
                        if (hwdata[2*i +: 2] != 2'h3) begin
                            nxt_st.pstate[2*i +: 2] = hwdata[2*i +: 2];  // [R2]
                        end
                    end
                end else if (st_ff.pend_addr == OFS_POWER) begin
                    wr_pwr = 1'b1;
                end else if (st_ff.pend_addr == OFS_IRQ_CLR) begin
                    clr_ev = hwdata[STS_W-1:0];
                end else if (st_ff.pend_addr == OFS_IRQ_EN) begin
                    nxt_st.ien = hwdata[STS_W-1:0];
                end else if (st_ff.pend_addr == OFS_SELF_RST) begin
                    nxt_st.self_rst = hwdata[0];
                end
            end else begin
                if (st_ff.pend_addr == OFS_DIR) begin
                    nxt_st.rdata = {28'h0, st_ff.dir};
                end else if (st_ff.pend_addr == OFS_PSTATE) begin
                    nxt_st.rdata = {24'h0, st_ff.pstate};
                end else if (st_ff.pend_addr == OFS_PIN_IN) begin
                    nxt_st.rdata = {27'h0, edge_bus.lvl};
                end else if (st_ff.pend_addr == OFS_POWER) begin
                    nxt_st.rdata = {30'h0, st_ff.pwr};
                end else if (st_ff.pend_addr == OFS_IRQ_STS) begin
                    nxt_st.rdata = {{(32-STS_W){1'b0}}, st_ff.sts};
                end else if (st_ff.pend_addr == OFS_IRQ_EN) begin
                    nxt_st.rdata = {{(32-STS_W){1'b0}}, st_ff.ien};
                end else if (st_ff.pend_addr == OFS_BOOT) begin
                    nxt_st.rdata = {31'h0, st_ff.boot};
                end else if (st_ff.pend_addr == OFS_SELF_RST) begin
                    nxt_st.rdata = {31'h0, st_ff.self_rst};
                end
            end
        end else if (hsel && htrans[1] && hready) begin
            nxt_st.pend = 1'b1;
            nxt_st.pend_wr = hwrite;
            nxt_st.pend_addr = haddr[7:0];
            nxt_st.hready_o = 1'b0;
        end

        // power sequencing
        case (st_ff.st)
            ST_START: begin
                nxt_st.settle = st_ff.settle + 2'h1;
                if (st_ff.settle == 2'(START_SETTLE_CYC - 1)) begin
                    nxt_st.st = wake_lvl ? ST_BOOT : ST_IDLE;  // [R7]
                end
            end
            ST_BOOT: begin
                if (!wake_lvl) begin
                    nxt_st.st = ST_IDLE;  // [R7]
                end
            end
            ST_IDLE: begin
                if (wr_pwr && hwdata[1:0] == PWR_STANDBY) begin
                    nxt_st.st = ST_STANDBY;
                end else if (wr_pwr && hwdata[1:0] == PWR_SLEEP) begin
                    nxt_st.st = ST_SLEEP;
                end
            end
            ST_STANDBY: begin
                if (wake_rise || gpio_act) begin
                    nxt_st.st = ST_WAKING;  // [R12]
                    nxt_st.from_sleep = 1'b0;
                    nxt_st.cnt = CNT_W'(WAKE_STBY_CYC - 1);
                end
            end
            ST_SLEEP: begin
                if (wake_rise) begin
                    nxt_st.st = ST_WAKING;  // [R5] [R12]
                    nxt_st.from_sleep = 1'b1;
                    nxt_st.cnt = CNT_W'(WAKE_SLP_CYC - 1);
                end
            end
            ST_WAKING: begin
                nxt_st.cnt = st_ff.cnt - CNT_W'(1);
                if (st_ff.cnt == '0) begin
                    set_ev[STS_READY] = 1'b1;  // [R13]
                    nxt_st.st = (st_ff.from_sleep && wake_lvl) ? ST_WAIT_LOW : ST_IDLE;
                end
            end
            ST_WAIT_LOW: begin
                if (!wake_lvl) begin
                    nxt_st.st = ST_IDLE;  // [R6]
                end
            end
            default: begin
                nxt_st.st = ST_IDLE;
            end
        endcase

        // events: set wins over clear
        set_ev[STS_WAKE] = wake_rise;
        set_ev[STS_GPIO] = gpio_act;
        nxt_st.sts = (st_ff.sts & ~clr_ev) | set_ev;

        // pads and status outputs
        for (int i = 0; i < 4; i++) begin
            pc = pad_ctl(st_ff.dir[i], st_ff.pstate[2*i +: 2]);
            nxt_st.pin_oe[i] = pc[3];
            nxt_st.pin_o[i] = pc[2];
            nxt_st.pin_pu[i] = pc[1];
            nxt_st.pin_pd[i] = pc[0];
        end
        nxt_st.wake_pd = 1'b1;  // [R8]
        nxt_st.rst_oe = st_ff.self_rst;  // [R10]
        nxt_st.pwr = pwr_code(st_ff.st);
        nxt_st.ready = (st_ff.st == ST_IDLE);  // [R13]
        nxt_st.boot = (st_ff.st == ST_BOOT) || (st_ff.st == ST_START);
        nxt_st.irq = |(st_ff.sts & st_ff.ien);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= '0;
            st_ff.st <= ST_START;
            st_ff.dir <= DIR_RST;
            st_ff.pstate <= PSTATE_RST;
            st_ff.hready_o <= 1'b1;
            st_ff.wake_pd <= 1'b1;
            st_ff.pwr <= PWR_BUSY;
            st_ff.boot <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hreadyout = st_ff.hready_o;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign general_io_pin_o = st_ff.pin_o;
    assign general_io_pin_oe = st_ff.pin_oe;
    assign general_io_pin_pu = st_ff.pin_pu;
    assign general_io_pin_pd = st_ff.pin_pd;
    assign wake_request_pin_pd = st_ff.wake_pd;
    assign reset_n_pin_o = 1'b0;
    assign reset_n_pin_oe = st_ff.rst_oe;
    assign power_mode = st_ff.pwr;
    assign cmd_ready = st_ff.ready;
    assign bootstrap_hold = st_ff.boot;
    assign irq = st_ff.irq;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_out_high0;
        st_ff.dir[0] && st_ff.pstate[1:0] == PS_HIGH;
    endsequence
    sequence s_in_low0;
        !st_ff.dir[0] && st_ff.pstate[1:0] == PS_LOW;
    endsequence

    property p_drive;
        s_out_high0 |=> general_io_pin_oe[0] && general_io_pin_o[0] && !general_io_pin_pu[0];
    endproperty
    a_drive: assert property (p_drive) else $error("pin 1 not driven high");  // [R3]

    property p_pull;
        s_in_low0 |=> general_io_pin_pd[0] && !general_io_pin_oe[0];
    endproperty
    a_pull: assert property (p_pull) else $error("pin 1 pull-down missing");  // [R4]

    property p_exclusive;
        ((general_io_pin_pu & general_io_pin_pd) == 4'h0)
            && ((general_io_pin_oe & (general_io_pin_pu | general_io_pin_pd)) == 4'h0);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("pull and drive overlap");  // [R2]

    property p_sleep_gpio;
        st_ff.st == ST_SLEEP && !wake_rise |=> st_ff.st == ST_SLEEP;
    endproperty
    a_sleep_gpio: assert property (p_sleep_gpio) else $error("sleep left without wake edge");  // [R12]

    property p_wake_rise;
        st_ff.st == ST_SLEEP && wake_rise |=> st_ff.st == ST_WAKING ##1 power_mode == PWR_BUSY;
    endproperty
    a_wake_rise: assert property (p_wake_rise) else $error("wake edge ignored in sleep");  // [R5]

    property p_wait_low;
        st_ff.st == ST_WAIT_LOW && wake_lvl |=> st_ff.st == ST_WAIT_LOW ##1 !cmd_ready;
    endproperty
    a_wait_low: assert property (p_wait_low) else $error("idle entered with wake high");  // [R6]

    property p_boot;
        st_ff.st == ST_BOOT && wake_lvl |=> bootstrap_hold && !cmd_ready;
    endproperty
    a_boot: assert property (p_boot) else $error("loader left with wake high");  // [R7]

    property p_wake_pd;
        wake_request_pin_pd;
    endproperty
    a_wake_pd: assert property (p_wake_pd) else $error("wake pull-down off");  // [R8]

    property p_self_rst;
        $rose(st_ff.self_rst) |=> reset_n_pin_oe && !reset_n_pin_o;
    endproperty
    a_self_rst: assert property (p_self_rst) else $error("reset pin not pulled low");  // [R10]

    property p_ready;
        st_ff.st == ST_WAKING && st_ff.cnt == '0 |=> st_ff.sts[STS_READY] ##1 $past(st_ff.st) != ST_WAKING;
    endproperty
    a_ready: assert property (p_ready) else $error("wake done not flagged");  // [R13]

    property p_rise_once;
        wake_rise |=> !wake_rise;
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("wake edge longer than a cycle");  // [R14]

    property p_irq;
        (st_ff.sts & st_ff.ien) != '0 |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled event did not raise irq");
endmodule

// ==== logic/gwc_pkg.sv ====
/*
 * gwc_pkg: register map, field codes, reset values and timing constants of
 * the general-purpose pin and wake control block.
 * Assumes a 40 MHz system clock and 32-bit AHB-Lite register access.
 */
package gwc_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_HZ = 40_000_000;
    localparam int WAKE_STANDBY_MS = 50;
    localparam int WAKE_SLEEP_MS = 60;
    localparam int WAKE_STANDBY_CYC = CLK_HZ / 1000 * WAKE_STANDBY_MS;
    localparam int WAKE_SLEEP_CYC = CLK_HZ / 1000 * WAKE_SLEEP_MS;
    localparam int START_SETTLE_CYC = 3;
    localparam int NUM_GPIO = 4;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_DIR = 8'h00;
    localparam logic [7:0] OFS_PSTATE = 8'h04;
    localparam logic [7:0] OFS_PIN_IN = 8'h08;
    localparam logic [7:0] OFS_POWER = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STS = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN = 8'h18;
    localparam logic [7:0] OFS_BOOT = 8'h1C;
    localparam logic [7:0] OFS_SELF_RST = 8'h20;

    // ==========================================================
    // field codes and reset values
    localparam logic [1:0] PS_LOW = 2'h0;
    localparam logic [1:0] PS_HIGH = 2'h1;
    localparam logic [1:0] PS_FLOAT = 2'h2;
    localparam logic [1:0] PWR_IDLE = 2'h0;
    localparam logic [1:0] PWR_STANDBY = 2'h1;
    localparam logic [1:0] PWR_SLEEP = 2'h2;
    localparam logic [1:0] PWR_BUSY = 2'h3;
    localparam logic [3:0] DIR_RST = 4'h0;
    localparam logic [7:0] PSTATE_RST = 8'hAA;
    localparam int STS_W = 3;
    localparam int STS_READY = 0;
    localparam int STS_WAKE = 1;
    localparam int STS_GPIO = 2;

    typedef enum logic [2:0] {
        ST_START,
        ST_BOOT,
        ST_IDLE,
        ST_STANDBY,
        ST_SLEEP,
        ST_WAKING,
        ST_WAIT_LOW
    } gwc_state_t;
endpackage

// ==== logic/gwc_edge_if.sv ====
/*
 * gwc_edge_if: raw pin levels into the synchroniser, clean levels and
 * one-cycle edge pulses out of it.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface gwc_edge_if #(parameter int W = 5);
    logic [W-1:0] raw;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] chg;
    modport det (input raw, output lvl, output rise, output chg);
    modport use_side (output raw, input lvl, input rise, input chg);
endinterface

// ==== logic/gwc_sync_edge.sv ====
/*
 * gwc_sync_edge: two-stage synchroniser plus edge detector per bit.
 * Assumes raw inputs may change at any time; sys_rst is synchronous.
 */
`timescale 1ns/1ps
module gwc_sync_edge #(
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic sys_rst,
    gwc_edge_if.det pins
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } gwc_sync_st_t;

    gwc_sync_st_t st_ff;
    gwc_sync_st_t nxt_st;

    // ==========================================================
    // synchroniser: s1 only feeds s2
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pins.raw;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pins.lvl = st_ff.s2;
    assign pins.rise = st_ff.s2 & ~st_ff.s3;  // [R14]
    assign pins.chg = st_ff.s2 ^ st_ff.s3;  // [R14]
endmodule

// ==== sim/gwc_pad_model.sv ====
/*
 * gwc_pad_model: board side of the four general pins, the wake pin and the
 * reset pin; resolves drive, pulls and outside drivers into pad levels.
 * Assumes the pad controls of gwc_top and a free-running bench clock.
 */
`timescale 1ns/1ps
module gwc_pad_model (
    input wire logic clk,
    input wire logic [3:0] pin_o,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pin_pu,
    input wire logic [3:0] pin_pd,
    input wire logic [3:0] ext_val,
    input wire logic [3:0] ext_en,
    input wire logic wake_val,
    input wire logic wake_en,
    input wire logic wake_pd,
    input wire logic rst_o,
    input wire logic rst_oe,
    output logic [3:0] pad,
    output logic wake_lvl,
    output logic rst_lvl_n
);
    logic flip_ff = 1'b0;
    always @(posedge clk) flip_ff <= ~flip_ff;
    always_comb begin
        // an undriven, unpulled pad wanders every cycle
        for (int i = 0; i < 4; i++) begin
            if (pin_oe[i]) pad[i] = pin_o[i];
            else if (ext_en[i]) pad[i] = ext_val[i];
            else if (pin_pu[i]) pad[i] = 1'b1;
            else if (pin_pd[i]) pad[i] = 1'b0;
            else pad[i] = flip_ff ^ i[0];
        end
        // host drives wake to wake_val while wake_en is set, otherwise leaves it open
        wake_lvl = wake_en ? wake_val : (wake_pd ? 1'b0 : flip_ff);
        // device side is open-drain only, the pin pulls itself up
        rst_lvl_n = (rst_oe && !rst_o) ? 1'b0 : 1'b1;
    end
endmodule

// ==== sim/gwc_top_tb.sv ====
/*
 * gwc_top_tb: self-checking bench for gwc_top with a behavioural pin model.
 * Assumes the pad model in gwc_pad_model and shortened wake counts.
 */
`timescale 1ns/1ps
module gwc_top_tb;
    import gwc_pkg::*;
    localparam int STBY_N = 20;
    localparam int SLP_N = 30;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, wake_pd, rst_o, rst_oe, cmd_ready, boot_hold, irq, wake_lvl, rst_lvl_n;
    logic [31:0] hrdata, r;
    logic [3:0] p_o, p_oe, p_pu, p_pd, pad, d;
    logic [3:0] ext_val = 4'h0;
    logic [3:0] ext_en = 4'h0;
    logic wake_val = 1'b0;
    logic wake_en = 1'b0;
    logic [1:0] power_mode;
    logic [7:0] w;
    logic [3:0] m_dir;
    int m_st[4];
    int s[4];
    int err_total = 0;
    int compares = 0;
    int cyc_cnt = 0;
    int n;

    gwc_top #(.WAKE_STBY_CYC(STBY_N), .WAKE_SLP_CYC(SLP_N)) gwc_top_inst (
        .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .general_io_pin_i(pad), .general_io_pin_o(p_o), .general_io_pin_oe(p_oe),
        .general_io_pin_pu(p_pu), .general_io_pin_pd(p_pd),
        .wake_request_pin_i(wake_lvl), .wake_request_pin_pd(wake_pd),
        .reset_n_pin_o(rst_o), .reset_n_pin_oe(rst_oe), .power_mode(power_mode),
        .cmd_ready(cmd_ready), .bootstrap_hold(boot_hold), .irq(irq));
    gwc_pad_model gwc_pad_model_inst (
        .clk(clk), .pin_o(p_o), .pin_oe(p_oe), .pin_pu(p_pu), .pin_pd(p_pd),
        .ext_val(ext_val), .ext_en(ext_en), .wake_val(wake_val), .wake_en(wake_en),
        .wake_pd(wake_pd), .rst_o(rst_o), .rst_oe(rst_oe), .pad(pad),
        .wake_lvl(wake_lvl), .rst_lvl_n(rst_lvl_n));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // helpers
    task automatic test_done();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_total = err_total + 1;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic ok;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do begin
            @(negedge clk);
            ok = hreadyout;
            @(posedge clk);
        end while (ok !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(negedge clk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge clk);
        end while (ok !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] dummy;
        ahb(1'b1, a, v, dummy);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        ahb(1'b0, a, 32'h0, v);
        chk(v & m, e);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wait_ready(output int k);
        k = 0;
        while (cmd_ready !== 1'b1) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic chk_pads();
        logic [3:0] e_oe, e_o, e_pu, e_pd;
        for (int i = 0; i < 4; i++) begin
            e_oe[i] = m_dir[i] && m_st[i] != 2;
            e_o[i] = m_st[i] == 1;
            e_pu[i] = !m_dir[i] && m_st[i] == 1;
            e_pd[i] = !m_dir[i] && m_st[i] == 0;
            w[2*i +: 2] = 2'(m_st[i]);
        end
        chk(32'(p_oe), 32'(e_oe));
        chk(32'(p_o & e_oe), 32'(e_o & e_oe));
        chk(32'(p_pu), 32'(e_pu));
        chk(32'(p_pd), 32'(e_pd));
    endtask
    task automatic setpins(input logic [3:0] dv, input logic [7:0] sv);
        m_dir = dv;
        for (int i = 0; i < 4; i++) m_st[i] = sv[2*i +: 2];
        wr(OFS_DIR, {28'h0, dv});
        wr(OFS_PSTATE, {24'h0, sv});
        cyc(3);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hD15B85DA));
        m_dir = 4'h0;
        for (int i = 0; i < 4; i++) m_st[i] = 2;
        cyc(19);
        chk(32'({irq, hreadyout, p_oe, p_pu, p_pd, wake_pd, rst_oe, boot_hold}), 32'h8005);
        @(posedge clk);
        sys_rst <= 1'b0;
        cyc(10);
        chk(32'({hresp, cmd_ready, boot_hold, power_mode, wake_pd}), 32'h11);
        chk_pads();
        rdchk(OFS_DIR, 32'hF, 32'h0);
        rdchk(OFS_PSTATE, 32'hFF, 32'hAA);
        rdchk(8'h24, 32'hFFFFFFFF, 32'h0);
        for (int k = 0; k < 8; k++) begin
            d = 4'($urandom_range(15));
            for (int i = 0; i < 4; i++) begin
                s[i] = $urandom_range(3);
                w[2*i +: 2] = 2'(s[i]);
                if (s[i] != 3) m_st[i] = s[i];
            end
            m_dir = d;
            wr(OFS_DIR, {28'h0, d});
            wr(OFS_PSTATE, {24'h0, w});
            cyc(2);
            chk_pads();
            rdchk(OFS_DIR, 32'hF, {28'h0, m_dir});
            rdchk(OFS_PSTATE, 32'hFF, {24'h0, w});
        end
        // startup with wake held high stays in the loader
        @(posedge clk);
        wake_en <= 1'b1;
        wake_val <= 1'b1;
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(40);
        chk(32'({boot_hold, cmd_ready}), 32'h2);
        rdchk(OFS_BOOT, 32'h1, 32'h1);
        @(posedge clk);
        wake_en <= 1'b0;
        cyc(10);
        chk(32'({boot_hold, cmd_ready}), 32'h1);
        setpins(4'h0, 8'h00);
        wr(OFS_IRQ_CLR, 32'h7);
        // standby left on a general pin edge
        wr(OFS_POWER, 32'h1);
        cyc(2);
        chk(32'(power_mode), 32'(PWR_STANDBY));
        @(posedge clk);
        ext_en <= 4'h2;
        ext_val <= 4'h2;
        wait_ready(n);
        chk(32'(n >= STBY_N && n <= STBY_N + 10), 32'h1);
        @(posedge clk);
        ext_en <= 4'h0;
        wake_en <= 1'b1;
        cyc(4);
        // sleep ignores a steady wake level and pin activity
        wr(OFS_POWER, 32'h2);
        @(posedge clk);
        ext_en <= 4'h1;
        ext_val <= 4'h1;
        cyc(40);
        chk(32'(power_mode), 32'(PWR_SLEEP));
        @(posedge clk);
        wake_val <= 1'b0;
        ext_en <= 4'h0;
        cyc(5);
        @(posedge clk);
        wake_val <= 1'b1;
        cyc(SLP_N + 10);
        chk(32'({cmd_ready, power_mode}), 32'(PWR_BUSY));
        @(posedge clk);
        wake_en <= 1'b0;
        wait_ready(n);
        chk(32'(n <= 8), 32'h1);
        // short pulse from sleep, wake time
        wr(OFS_IRQ_CLR, 32'h7);
        wr(OFS_POWER, 32'h2);
        @(posedge clk);
        wake_en <= 1'b1;
        repeat (4) @(posedge clk);
        wake_en <= 1'b0;
        wait_ready(n);
        chk(32'(n + 4 >= SLP_N && n <= SLP_N + 10), 32'h1);
        // interrupt raise, mask, clear
        rdchk(OFS_IRQ_STS, 32'h7, 32'h3);
        wr(OFS_IRQ_EN, 32'h2);
        cyc(2);
        chk(32'(irq), 32'h1);
        wr(OFS_IRQ_EN, 32'h0);
        cyc(2);
        chk(32'(irq), 32'h0);
        wr(OFS_IRQ_EN, 32'h2);
        wr(OFS_IRQ_CLR, 32'h2);
        cyc(2);
        chk(32'(irq), 32'h0);
        rdchk(OFS_IRQ_STS, 32'h2, 32'h0);
        // self reset pulls the open-drain pin low
        wr(OFS_SELF_RST, 32'h1);
        cyc(2);
        chk(32'(rst_lvl_n), 32'h0);
        wr(OFS_SELF_RST, 32'h0);
        cyc(2);
        chk(32'(rst_lvl_n), 32'h1);
        // synchronised input levels read back
        setpins(4'hF, 8'h45);
        cyc(2);
        chk_pads();
        rdchk(OFS_PIN_IN, 32'h1F, 32'h0B);
        test_done();
    end
endmodule
